// ---- rtl/fdc_cmd_pkg.sv ----
// Constants, types and register map of the read command sequencer.
// Assumes one 100 MHz clock and a byte-wide host register port.
package fdc_cmd_pkg;
  // ==========================================================
  // Register map (word index on the host port)
  localparam logic [1:0] REG_FIFO = 2'h0;
  localparam logic [1:0] REG_STATUS = 2'h1;
  localparam logic [1:0] REG_CONFIG = 2'h2;
  // ==========================================================
  // Opcode patterns
  localparam logic [4:0] OP_RDEL = 5'h0c;
  localparam logic [5:0] OP_RID = 6'h0a;
  localparam logic [4:0] OP_RTRK = 5'h02;
  localparam logic [3:0] LEN_LONG = 4'h9;
  localparam logic [3:0] LEN_ID = 4'h2;
  localparam logic [2:0] RES_LAST = 3'h6;
  // ==========================================================
  // Status fields
  localparam logic [1:0] IC_NORMAL = 2'h0;
  localparam logic [1:0] IC_ABNORMAL = 2'h1;
  localparam int ST1_MA_BIT = 0;
  localparam int ST1_MD_BIT = 2;
  localparam int ST1_OR_BIT = 4;
  localparam int ST1_CRC_BIT = 5;
  localparam int ST1_EOT_BIT = 7;
  localparam int ST2_DD_BIT = 5;
  localparam int ST2_CM_BIT = 6;
  localparam int DLY_W = 16;
  localparam logic [DLY_W-1:0] PROC_DELAY_DEF = 16'h0064;
  localparam logic [7:0] BYTE_RST = 8'h00;
  // ==========================================================
  // Sequencer states, Gray coded along the command path
  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_CMD = 3'h1,
    S_DELAY = 3'h3,
    S_IDXW = 3'h2,
    S_SEARCH = 3'h6,
    S_DATA = 3'h7,
    S_XFER = 3'h5,
    S_RESULT = 3'h4
  } state_t;
  typedef enum logic [1:0] {
    CMD_NONE = 2'h0,
    CMD_RDEL = 2'h1,
    CMD_RID = 2'h2,
    CMD_RTRK = 2'h3
  } cmd_t;
endpackage : fdc_cmd_pkg

// ---- rtl/fdc_read_cmds.sv ----
// Read-deleted-data, read-ID and read-a-track sequencer.
// Assumes a data separator that pulses index, address field, data
// mark, byte and sector end events, all synchronous to clk_in.
//
// Operation
// [RQ1] Deleted-data bytes go out by DMA or polling
// [RQ2] Below end sector: report sector plus one
// [RQ3] Single side at end: track plus one, sector 1
// [RQ4] Multi side at end: swap head, sector 1
// [RQ5] Skip clear: normal sector read, mark, stop
// [RQ6] Skip set: normal sector marked and skipped
// [RQ7] Decode two-byte read-ID command
// [RQ8] Read-ID returns first address field found
// [RQ9] Wait processing delay before separator search
// [RQ10] Host turns drive motor on during delay
// [RQ11] Read-ID moves no data, interrupts at end
// [RQ12] Read-ID performs no implied seek
// [RQ13] Read-ID error sets abnormal interrupt code
// [RQ14] Host FIFO write aborts the address search
// [RQ15] Two index pulses without mark: missing mark
// [RQ16] Seven result bytes in fixed order
// [RQ17] Read-a-track reads sectors in physical order
// [RQ18] Host keeps track opcode multi/skip bits zero
// [RQ19] Accept nine-byte read-a-track command
// [RQ20] Deleted read follows the data read flow
// [RQ21] Interrupt at result phase, host reads bytes
// [RQ22] Terminal count ends with normal code
// [RQ23] Drive busy from last byte to result
`timescale 1ns/100ps
module fdc_read_cmds #(
  parameter logic [fdc_cmd_pkg::DLY_W-1:0] PROC_DELAY_CYC = fdc_cmd_pkg::PROC_DELAY_DEF
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic [1:0] bus_addr_in,
  input wire logic [7:0] bus_wdata_in,
  input wire logic bus_wr_in,
  input wire logic bus_rd_in,
  output logic [7:0] bus_rdata_out,
  output logic floppy_interrupt_line_out,
  output logic [3:0] drive_busy_out,
  output logic separator_on_out,
  output logic double_density_select_out,
  output logic head_select_out,
  output logic [1:0] drive_select_out,
  input wire logic index_in,
  input wire logic am_found_in,
  input wire logic [7:0] id_track_in,
  input wire logic [7:0] id_head_in,
  input wire logic [7:0] id_sector_in,
  input wire logic [7:0] id_size_in,
  input wire logic id_crc_err_in,
  input wire logic data_mark_in,
  input wire logic deleted_mark_in,
  input wire logic disk_byte_valid_in,
  input wire logic [7:0] disk_byte_in,
  input wire logic sector_end_in,
  input wire logic data_crc_err_in,
  input wire logic tc_in,
  input wire logic dma_ack_in,
  output logic dma_req_out,
  output logic [7:0] dma_data_out
);
  import fdc_cmd_pkg::*;

  typedef struct packed {
    state_t st;
    cmd_t cmd;
    logic [3:0] cnt;
    logic mt;
    logic sk;
    logic double_density_select;
    logic hd;
    logic [1:0] ds;
    logic [7:0] trk;
    logic [7:0] head;
    logic [7:0] sec;
    logic [7:0] size;
    logic [7:0] last_sector_number;
    logic [DLY_W-1:0] dly;
    logic idx;
    logic tc;
    logic stop;
    logic [7:0] st0;
    logic [7:0] st1;
    logic [7:0] st2;
    logic [2:0] rp;
    logic [7:0] hold;
    logic full;
    logic dma_mode;
    logic irq;
    logic [3:0] busy;
    logic sep;
    logic dreq;
    logic [7:0] rdata;
  } regs_t;

  regs_t s;
  regs_t n;

  // ==========================================================
  // Next-state logic
  always_comb
  begin
    logic fifo_wr;
    logic fifo_rd;
    logic adv;
    logic fin;
    logic rep;
    logic [1:0] ic;
    logic [1:0] sel;
    logic idmatch;
    n = s;
    fifo_wr = bus_wr_in && (bus_addr_in == REG_FIFO);
    fifo_rd = bus_rd_in && (bus_addr_in == REG_FIFO);
    adv = 1'b0;
    fin = 1'b0;
    rep = 1'b0;
    ic = IC_NORMAL;
    sel = s.ds;
    idmatch = (id_track_in == s.trk) && (id_head_in == s.head) &&
              (id_size_in == s.size);
    n.rdata = BYTE_RST;

    if (bus_wr_in && bus_addr_in == REG_CONFIG)
    begin
      n.dma_mode = bus_wdata_in[0];
    end
    if (bus_rd_in)
    begin
      case (bus_addr_in)
        REG_STATUS: n.rdata = {s.busy, s.st == S_RESULT,
                               s.st != S_IDLE && s.st != S_CMD && s.st != S_RESULT,
                               s.full && !s.dma_mode, s.st == S_IDLE || s.st == S_CMD};
        REG_CONFIG: n.rdata = {7'h00, s.dma_mode};
        default: n.rdata = BYTE_RST;
      endcase
    end
    // Terminal count is remembered and acted on at the sector boundary
    if (tc_in && s.cmd != CMD_RID && s.sep)
    begin
      n.tc = 1'b1;
    end

    case (s.st)
      S_IDLE:
      begin
        if (fifo_wr)
        begin
          n.cnt = 4'h1;
          n.double_density_select = bus_wdata_in[6];
          n.st0 = BYTE_RST;
          n.st1 = BYTE_RST;
          n.st2 = BYTE_RST;
          n.tc = 1'b0;
          n.stop = 1'b0;
          n.st = S_CMD;
          n.mt = 1'b0;
          n.sk = 1'b0;
          if (bus_wdata_in[4:0] == OP_RDEL)
          begin
            n.cmd = CMD_RDEL;
            n.mt = bus_wdata_in[7];
            n.sk = bus_wdata_in[5];
          end
          else if (!bus_wdata_in[7] && bus_wdata_in[5:0] == OP_RID) // [RQ7]
          begin
            n.cmd = CMD_RID;
          end
          else if (bus_wdata_in[4:0] == OP_RTRK) // [RQ19]
          begin
            n.cmd = CMD_RTRK;
          end
          else
          begin
            // Opcodes outside this sequencer are dropped
            n.cmd = CMD_NONE;
            n.st = S_IDLE;
          end
        end
      end
      S_CMD:
      begin
        if (fifo_wr)
        begin
          n.cnt = s.cnt + 4'h1;
          case (s.cnt)
            4'h1:
            begin
              n.hd = bus_wdata_in[2]; // [RQ7] [RQ19]
              n.ds = bus_wdata_in[1:0];
              sel = bus_wdata_in[1:0];
            end
            4'h2: n.trk = bus_wdata_in;
            4'h3: n.head = bus_wdata_in;
            4'h4: n.sec = bus_wdata_in;
            4'h5: n.size = bus_wdata_in;
            4'h6: n.last_sector_number = bus_wdata_in;
            default: n.cnt = s.cnt + 4'h1;
          endcase
          if (s.cnt + 4'h1 == (s.cmd == CMD_RID ? LEN_ID : LEN_LONG))
          begin
            n.busy[sel] = 1'b1; // [RQ23]
            n.dly = PROC_DELAY_CYC;
            n.st = S_DELAY;
          end
        end
      end
      S_DELAY:
      begin
        // Head stays where it is: implied seek is not supported [RQ12]
        n.dly = s.dly - 1'b1;
        if (s.dly == '0)
        begin
          n.sep = 1'b1; // [RQ9]
          n.idx = 1'b0;
          n.st = S_SEARCH;
          if (s.cmd == CMD_RTRK)
          begin
            n.sec = 8'h01;
            n.st = S_IDXW;
          end
        end
      end
      S_IDXW:
      begin
        if (fifo_wr)
        begin
          fin = 1'b1;
          ic = IC_ABNORMAL;
        end
        else if (index_in)
        begin
          n.st = S_SEARCH;
        end
      end
      S_SEARCH, S_DATA:
      begin
        if (fifo_wr && s.st == S_SEARCH)
        begin
          fin = 1'b1; // [RQ14]
          ic = IC_ABNORMAL; // [RQ13]
        end
        else if (index_in && s.idx)
        begin
          n.st1[ST1_MA_BIT] = 1'b1; // [RQ15]
          fin = 1'b1;
          ic = IC_ABNORMAL; // [RQ13]
        end
        else if (s.st == S_SEARCH && am_found_in)
        begin
          if (s.cmd == CMD_RID)
          begin
            n.trk = id_track_in; // [RQ8]
            n.head = id_head_in;
            n.sec = id_sector_in;
            n.size = id_size_in;
            fin = 1'b1; // [RQ11]
          end
          else if (s.cmd == CMD_RTRK)
          begin
            // Every sector is taken in the order it passes the head [RQ17]
            n.st1[ST1_MD_BIT] = s.st1[ST1_MD_BIT] | !idmatch;
            n.st1[ST1_CRC_BIT] = s.st1[ST1_CRC_BIT] | id_crc_err_in;
            n.st = S_DATA;
            n.idx = 1'b0;
          end
          else if (idmatch && id_sector_in == s.sec)
          begin
            n.st = S_DATA; // [RQ20]
            n.idx = 1'b0;
            if (id_crc_err_in)
            begin
              n.st1[ST1_CRC_BIT] = 1'b1;
              fin = 1'b1;
              ic = IC_ABNORMAL;
            end
          end
        end
        else if (s.st == S_DATA && data_mark_in)
        begin
          n.st = S_XFER;
          if (s.cmd == CMD_RDEL && !deleted_mark_in)
          begin
            n.st2[ST2_CM_BIT] = 1'b1; // [RQ5] [RQ6]
            if (s.sk)
            begin
              adv = 1'b1; // [RQ6]
            end
            else
            begin
              n.stop = 1'b1; // [RQ5]
            end
          end
        end
        if (index_in)
        begin
          n.idx = 1'b1;
        end
      end
      S_XFER:
      begin
        // A drain in the same cycle frees the holder before a new byte lands
        if (dma_ack_in && s.dreq)
        begin
          n.full = 1'b0;
          n.dreq = 1'b0;
        end
        if (fifo_rd && s.full && !s.dma_mode)
        begin
          n.full = 1'b0;
        end
        if (disk_byte_valid_in)
        begin
          if (n.full)
          begin
            // Host was too slow; the byte already held is kept
            n.st1[ST1_OR_BIT] = 1'b1;
            fin = 1'b1;
            ic = IC_ABNORMAL;
          end
          else
          begin
            n.hold = disk_byte_in; // [RQ1]
            n.full = 1'b1;
            n.dreq = s.dma_mode; // [RQ1]
          end
        end
        if (sector_end_in && !fin)
        begin
          adv = 1'b1;
          if (data_crc_err_in)
          begin
            n.st1[ST1_CRC_BIT] = 1'b1;
            n.st2[ST2_DD_BIT] = 1'b1;
            if (s.cmd == CMD_RDEL)
            begin
              adv = 1'b0;
              fin = 1'b1;
              ic = IC_ABNORMAL;
            end
          end
        end
      end
      S_RESULT:
      begin
        if (fifo_rd)
        begin
          n.irq = 1'b0;
          n.rp = s.rp + 3'h1;
          case (s.rp) // [RQ16]
            3'h0: n.rdata = s.st0;
            3'h1: n.rdata = s.st1;
            3'h2: n.rdata = s.st2;
            3'h3: n.rdata = s.trk;
            3'h4: n.rdata = s.head;
            3'h5: n.rdata = s.sec;
            default: n.rdata = s.size;
          endcase
          if (s.rp == RES_LAST)
          begin
            n.st = S_IDLE;
            n.cmd = CMD_NONE;
          end
        end
      end
      default: n.st = S_IDLE;
    endcase

    // Polled transfer: host drains the held byte through the FIFO port
    if (fifo_rd && s.st != S_RESULT && s.full && !s.dma_mode)
    begin
      n.rdata = s.hold; // [RQ1]
      if (s.st != S_XFER)
      begin
        n.full = 1'b0;
      end
    end

    // ==========================================================
    // Sector boundary: terminal count, stop, end of track or next sector
    if (adv)
    begin
      n.idx = 1'b0;
      n.st = S_SEARCH;
      if (s.tc)
      begin
        fin = 1'b1; // [RQ22]
        rep = 1'b1;
      end
      else if (n.stop)
      begin
        fin = 1'b1; // [RQ5]
        rep = 1'b1;
      end
      else if (s.sec == s.last_sector_number)
      begin
        if (s.mt && !s.hd)
        begin
          n.hd = 1'b1; // [RQ4]
          n.head = 8'h01;
          n.sec = 8'h01;
        end
        else
        begin
          n.st1[ST1_EOT_BIT] = 1'b1;
          fin = 1'b1;
          rep = 1'b1;
          ic = IC_ABNORMAL;
        end
      end
      else
      begin
        n.sec = s.sec + 8'h01;
      end
    end

    if (fin)
    begin
      n.st0 = {ic, 3'h0, n.hd, s.ds}; // [RQ13] [RQ22]
      n.st = S_RESULT;
      n.rp = 3'h0;
      n.irq = 1'b1; // [RQ11] [RQ21]
      n.busy = 4'h0; // [RQ23]
      n.sep = 1'b0;
      n.dreq = 1'b0;
      n.full = 1'b0;
      if (rep)
      begin
        if (s.sec != s.last_sector_number)
        begin
          n.sec = s.sec + 8'h01; // [RQ2]
        end
        else
        begin
          n.sec = 8'h01;
          if (!s.mt)
          begin
            n.trk = s.trk + 8'h01; // [RQ3]
          end
          else if (!s.hd)
          begin
            n.head = 8'h01; // [RQ4]
          end
          else
          begin
            n.head = 8'h00; // [RQ4]
            n.trk = s.trk + 8'h01;
          end
        end
      end
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      s <= '0;
      s.st <= S_IDLE;
      s.cmd <= CMD_NONE;
    end
    else
    begin
      s <= n;
    end
  end

  assign bus_rdata_out = s.rdata;
  assign floppy_interrupt_line_out = s.irq;
  assign drive_busy_out = s.busy;
  assign separator_on_out = s.sep;
  assign double_density_select_out = s.double_density_select;
  assign head_select_out = s.hd;
  assign drive_select_out = s.ds;
  assign dma_req_out = s.dreq;
  assign dma_data_out = s.hold;
endmodule : fdc_read_cmds

// ---- tb/drive_model.sv ----
// Drive and data separator model facing the read sequencer.
// Assumes the bench picks the disk kind; timing counts from separator start.
`timescale 1ns/100ps
module drive_model (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic separator_on_in,
  input wire logic [1:0] mode_in,
  input wire logic deleted_in,
  input wire logic [7:0] head_in,
  input wire logic [7:0] sector_in,
  output logic index_out,
  output logic am_out,
  output logic [7:0] track_out,
  output logic [7:0] head_out,
  output logic [7:0] sector_out,
  output logic [7:0] size_out,
  output logic mark_out,
  output logic deleted_out,
  output logic byte_valid_out,
  output logic [7:0] byte_out,
  output logic end_out
);
  logic [6:0] cnt;
  logic fmt;
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in || !separator_on_in)
      cnt <= 7'h00;
    else
      cnt <= cnt + 7'h01;
  end
  // Mode 0 no disk, 1 blank disk, 2 formatted
  assign fmt = mode_in == 2'h2;
  assign index_out = (mode_in != 2'h0) && (cnt[5:0] == 6'h3f);
  assign am_out = fmt && (cnt == 7'h05);
  // Id lines show inverted junk outside the mark cycle
  assign track_out = am_out ? 8'h12 : 8'hed;
  assign head_out = am_out ? head_in : ~head_in;
  assign sector_out = am_out ? sector_in : ~sector_in;
  assign size_out = am_out ? 8'h02 : 8'hfd;
  assign mark_out = fmt && (cnt == 7'h08);
  assign deleted_out = mark_out ? deleted_in : ~deleted_in;
  assign byte_valid_out = fmt && (cnt == 7'h0a);
  assign byte_out = byte_valid_out ? 8'ha5 : 8'h5a;
  // Late sector end leaves the host time to poll the held byte
  assign end_out = fmt && (cnt == 7'h28);
endmodule : drive_model

// ---- tb/fdc_read_cmds_assertions.sv ----
// Port checker for the read command sequencer.
// Assumes a bind to fdc_read_cmds; one clock, synchronous reset.
`timescale 1ns/100ps
module fdc_read_cmds_chk #(
  parameter logic [15:0] PROC_DELAY_CYC = 16'h0002
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic [1:0] bus_addr_in,
  input wire logic bus_wr_in,
  input wire logic bus_rd_in,
  input wire logic [7:0] bus_rdata_out,
  input wire logic floppy_interrupt_line_out,
  input wire logic [3:0] drive_busy_out,
  input wire logic separator_on_out,
  input wire logic double_density_select_out,
  input wire logic [1:0] drive_select_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);
  // ==========================================================
  // Properties
  rdata_idle_a: assert property (!$past(bus_rd_in) |-> bus_rdata_out == 8'h00)
    else $error("read data outside answer cycle");
  irq_hold_a: assert property (floppy_interrupt_line_out
    && !(bus_rd_in && bus_addr_in == 2'h0) |=> floppy_interrupt_line_out)
    else $error("interrupt dropped early");
  irq_clear_a: assert property (floppy_interrupt_line_out
    && bus_rd_in && bus_addr_in == 2'h0 |=> !floppy_interrupt_line_out)
    else $error("interrupt not cleared");
  irq_quiet_a: assert property (floppy_interrupt_line_out
    |-> drive_busy_out == 4'h0 && !separator_on_out)
    else $error("interrupt while busy");
  sep_busy_a: assert property (separator_on_out |-> drive_busy_out != 4'h0)
    else $error("separator on while idle");
  sep_delay_a: assert property ($rose(separator_on_out) |-> $past(drive_busy_out, 2) != 4'h0)
    else $error("separator started without delay");
  busy_cause_a: assert property ($rose(drive_busy_out != 4'h0)
    |-> $past(bus_wr_in && bus_addr_in == 2'h0))
    else $error("busy without command byte");
  sel_stable_a: assert property (drive_busy_out != 4'h0 && $past(drive_busy_out) != 4'h0
    |-> $stable(drive_select_out) && $stable(double_density_select_out))
    else $error("selection moved while busy");
endmodule : fdc_read_cmds_chk

// ---- tb/tb_fdc_read_cmds.sv ----
// Bench for the read command sequencer, host side by register port.
// Assumes drive_model as the disk and a short processing delay.
`timescale 1ns/100ps
module tb_fdc_read_cmds;
  import fdc_cmd_pkg::*;
  localparam logic [15:0] PROC_DELAY_CYC = 16'h0002;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [1:0] bus_addr_in = 2'h0;
  logic [7:0] bus_wdata_in = 8'h00;
  logic bus_wr_in = 1'b0;
  logic bus_rd_in = 1'b0;
  logic [1:0] mode = 2'h0;
  logic del = 1'b0;
  logic [7:0] hd = 8'h00;
  logic [7:0] sec = 8'h03;
  logic ack = 1'b0;
  logic tc = 1'b0;
  logic [7:0] rdata;
  logic irq, sep, dens, head, idx, am, mark, dm, bv, send, dreq;
  logic [1:0] drv;
  logic [3:0] busy;
  logic [7:0] trk, ihd, isec, isz, byt, ddat;
  int mismatches = 0;
  int checks_done = 0;
  fdc_read_cmds #(.PROC_DELAY_CYC(PROC_DELAY_CYC)) dut_u (.clk_in(clk_in),
    .sys_rst_in(sys_rst_in), .bus_addr_in(bus_addr_in), .bus_wdata_in(bus_wdata_in),
    .bus_wr_in(bus_wr_in), .bus_rd_in(bus_rd_in), .bus_rdata_out(rdata),
    .floppy_interrupt_line_out(irq), .drive_busy_out(busy), .separator_on_out(sep),
    .double_density_select_out(dens), .head_select_out(head), .drive_select_out(drv),
    .index_in(idx), .am_found_in(am), .id_track_in(trk), .id_head_in(ihd),
    .id_sector_in(isec), .id_size_in(isz), .id_crc_err_in(1'b0), .data_mark_in(mark),
    .deleted_mark_in(dm), .disk_byte_valid_in(bv), .disk_byte_in(byt),
    .sector_end_in(send), .data_crc_err_in(1'b0), .tc_in(tc), .dma_ack_in(ack),
    .dma_req_out(dreq), .dma_data_out(ddat));
  drive_model disk_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .separator_on_in(sep),
    .mode_in(mode), .deleted_in(del), .head_in(hd), .sector_in(sec), .index_out(idx),
    .am_out(am), .track_out(trk), .head_out(ihd), .sector_out(isec), .size_out(isz),
    .mark_out(mark), .deleted_out(dm), .byte_valid_out(bv), .byte_out(byt), .end_out(send));
  initial
  begin
    forever #5 clk_in = ~clk_in;
  end
  // ==========================================================
  // Host tasks
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    checks_done++;
    if (s !== e)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_in);
    bus_addr_in <= a;
    bus_wdata_in <= d;
    bus_wr_in <= 1'b1;
    @(posedge clk_in);
    bus_wr_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] a, input logic [7:0] e, input bit c);
    @(posedge clk_in);
    bus_addr_in <= a;
    bus_rd_in <= 1'b1;
    @(posedge clk_in);
    bus_rd_in <= 1'b0;
    #1;
    if (c)
      chk("read", e, rdata);
  endtask : rd
  task automatic cmd(input logic [7:0] b[$]);
    foreach (b[i]) wr(REG_FIFO, b[i]);
    #1;
  endtask : cmd
  // Always drains all seven bytes so the sequencer returns to idle
  task automatic res(input logic [7:0] e[$]);
    for (int i = 0; i < 7; i++) rd(REG_FIFO, (i < e.size()) ? e[i] : 8'h00, i < e.size());
  endtask : res
  task automatic wait_hi(input bit s);
    int i;
    for (i = 0; i < 3000; i++)
    begin
      @(posedge clk_in);
      #1;
      if ((s ? sep : irq) === 1'b1)
        break;
    end
    if (i == 3000)
    begin
      mismatches++;
      $display("CHECK FAILED wait expected 1 seen 0");
      complete_run();
    end
  endtask : wait_hi
  task automatic rdel(input logic [7:0] op, b2, h, last_sector_number, input logic d, input logic [7:0] e[$]);
    mode <= 2'h2;
    hd <= h;
    del <= d;
    cmd('{op, b2, 8'h12, h, 8'h03, 8'h02, last_sector_number, 8'h1b, 8'hff});
    wait_hi(1'b1);
    repeat (14) @(posedge clk_in);
    rd(REG_STATUS, op[5] ? 8'h14 : 8'h16, 1'b1);
    rd(REG_FIFO, op[5] ? 8'h00 : 8'ha5, 1'b1);
    wait_hi(1'b0);
    res(e);
  endtask : rdel
  task complete_run;
    $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  // ==========================================================
  // Scenarios
  initial
  begin
    repeat (3) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    chk("irq", 8'h00, {7'h00, irq});
    rd(REG_STATUS, 8'h01, 1'b1);
    rd(REG_CONFIG, 8'h00, 1'b1);
    rd(2'h3, 8'h00, 1'b1);
    wr(REG_FIFO, 8'h1f);
    rd(REG_STATUS, 8'h01, 1'b1);
    mode <= 2'h2;
    hd <= 8'h01;
    sec <= 8'h07;
    cmd('{8'h4a, 8'h05});
    chk("busy", 8'h02, {4'h0, busy});
    chk("select", 8'h0d, {4'h0, dens, head, drv});
    wait_hi(1'b0);
    res('{8'h05, 8'h00, 8'h00, 8'h12, 8'h01, 8'h07, 8'h02});
    mode <= 2'h1;
    cmd('{8'h0a, 8'h00});
    wait_hi(1'b0);
    res('{8'h40, 8'h01, 8'h00});
    mode <= 2'h0;
    cmd('{8'h4a, 8'h02});
    wait_hi(1'b1);
    wr(REG_FIFO, 8'h00);
    wait_hi(1'b0);
    res('{8'h42});
    cmd('{8'h42, 8'h01, 8'h12, 8'h00, 8'h01, 8'h02, 8'h09, 8'h1b, 8'hff});
    wait_hi(1'b1);
    wr(REG_FIFO, 8'h00);
    wait_hi(1'b0);
    res('{8'h41});
    sec <= 8'h03;
    rdel(8'h4c, 8'h00, 8'h00, 8'h09, 1'b0, '{8'h00, 8'h00, 8'h40, 8'h12, 8'h00, 8'h04});
    rdel(8'h4c, 8'h00, 8'h00, 8'h03, 1'b1, '{8'h40, 8'h80, 8'h00, 8'h13, 8'h00, 8'h01});
    rdel(8'hcc, 8'h04, 8'h01, 8'h03, 1'b1, '{8'h44, 8'h80, 8'h00, 8'h13, 8'h00, 8'h01});
    rdel(8'h6c, 8'h00, 8'h00, 8'h09, 1'b0, '{8'h40, 8'h01, 8'h40});
    // DMA transfer, acknowledged, then ended by terminal count
    wr(REG_CONFIG, 8'h01);
    rd(REG_CONFIG, 8'h01, 1'b1);
    del <= 1'b1;
    cmd('{8'h4c, 8'h00, 8'h12, 8'h00, 8'h03, 8'h02, 8'h09, 8'h1b, 8'hff});
    wait_hi(1'b1);
    repeat (14) @(posedge clk_in);
    #1;
    chk("dreq", 8'h01, {7'h00, dreq});
    chk("dma_data", 8'ha5, ddat);
    @(posedge clk_in);
    ack <= 1'b1;
    tc <= 1'b1;
    @(posedge clk_in);
    ack <= 1'b0;
    tc <= 1'b0;
    #1;
    chk("dreq_ack", 8'h00, {7'h00, dreq});
    wait_hi(1'b0);
    res('{8'h00, 8'h00, 8'h00, 8'h12, 8'h00, 8'h04, 8'h02});
    wr(REG_CONFIG, 8'h00);
    complete_run();
  end
endmodule : tb_fdc_read_cmds
bind fdc_read_cmds fdc_read_cmds_chk #(.PROC_DELAY_CYC(PROC_DELAY_CYC)) chk_u (
  .clk_in(clk_in), .sys_rst_in(sys_rst_in), .bus_addr_in(bus_addr_in),
  .bus_wr_in(bus_wr_in), .bus_rd_in(bus_rd_in), .bus_rdata_out(bus_rdata_out),
  .floppy_interrupt_line_out(floppy_interrupt_line_out), .drive_busy_out(drive_busy_out),
  .separator_on_out(separator_on_out), .double_density_select_out(double_density_select_out),
  .drive_select_out(drive_select_out));
